/* File: verilog/lhr_pkg.sv */
// Shared constants and carriers of the LCD host RAM access block
package lhr_pkg;
	// Display RAM geometry
	localparam int unsigned COLS       = 132;
	localparam int unsigned PAGES      = 9;
	localparam int unsigned RAM_WORDS  = COLS * PAGES;
	localparam logic [3:0]  IND_PAGE   = 4'h8;
	localparam logic [6:0]  IND_LINE   = 7'h40;
	localparam logic [7:0]  COL_LAST   = 8'h83;
	localparam logic [7:0]  COL_LOCK   = 8'h84;
	localparam int unsigned STAT_BUSY  = 7;

	// Busy time after each command or data write
	localparam int unsigned CLK_PS     = 4000;
	localparam int unsigned BUSY_PS    = 20000;
	localparam int unsigned BUSY_CYC   = (BUSY_PS + CLK_PS - 1) / CLK_PS;
	localparam logic [3:0]  BUSY_LOAD  = 4'(BUSY_CYC);

	// Command codes: value masked by the mask equals the match
	localparam logic [7:0]  CMD_COL_LO  = 8'h00;
	localparam logic [7:0]  CMD_COL_HI  = 8'h10;
	localparam logic [7:0]  MSK_NIBBLE  = 8'hF0;
	localparam logic [7:0]  CMD_START   = 8'h40;
	localparam logic [7:0]  MSK_START   = 8'hC0;
	localparam logic [7:0]  CMD_ADC     = 8'hA0;
	localparam logic [7:0]  MSK_ADC     = 8'hFE;
	localparam logic [7:0]  CMD_PAGE    = 8'hB0;
	localparam logic [7:0]  CMD_OUTSEL  = 8'hC0;
	localparam int unsigned OUTSEL_DIR  = 3;

	// Reset values
	localparam logic [5:0]  START_RST  = 6'h00;
	localparam logic [3:0]  PAGE_RST   = 4'h0;
	localparam logic [7:0]  COL_RST    = 8'h00;

	// Pins of the parallel port and display timing, sampled as one word
	typedef struct packed {
		logic       ps;
		logic       c86;
		logic       cs_n;
		logic       cs;
		logic       dcs;
		logic       rd;
		logic       wr;
		logic       fr;
		logic       cl;
		logic [7:0] d;
	} lhr_pins_s;

	// Byte handed from the serial clock domain
	typedef struct packed {
		logic [7:0] word;
		logic       dcs;
		logic       tog;
	} lhr_hand_s;
endpackage

/* File: verilog/lhr_host_port.sv */
// Host access port, display RAM and line scan of the LCD driver
//
// Function
// - Interface select high picks parallel bus, low picks serial; serial cannot read RAM.
// - Bus style select high gives 6800 style, low gives 8080 style.
// - Data/command high reads or writes RAM; low reads status or writes command.
// - Serial: 7-bit shift plus input bit, 3-bit count, MSB first, byte done each eighth edge.
// - Serial inputs work only while selected; otherwise shift and count held reset.
// - Data/command sampled on eighth serial edge marks byte as data or command.
// - Deselected chip floats data pins and ignores strobes and data/command.
// - RAM reads pipeline through a bus holder; first read after addressing is stale.
// - Data write is held in the bus holder, then committed before next write.
// - While busy only status reads are accepted; busy shows on D7.
// - Start line command loads a 6-bit first displayed RAM line.
// - Line counter preset from start line on frame change, stepped by line clock.
// - 8-bit column counter steps by one per data access, separate from page.
// - Column set above 84H locks the counter until a new column is set.
// - Segment reversal maps first output to column 83H instead of 0.
// - 4-bit page register set by page command selects host page.
// - Page 8 is the indicator row; only D0 is kept.
// - RAM is 65 lines by 132 columns, eight pages plus indicator page.
// - Refresh reads run independently of host access.
// - Output status bit D3 selects common scan direction.
// - Each line clock latches the 132-bit row of the current line to segments.
`timescale 1ns/1ps
`default_nettype none
module lhr_host_port (
	// System
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	// Serial link
	input  wire logic         serial_clk_in,
	input  wire logic         serial_data_in,
	// Host pins
	input  wire logic         interface_select_in,
	input  wire logic         bus_style_select_in,
	input  wire logic         chip_select_low_n_in,
	input  wire logic         chip_select_high_in,
	input  wire logic         data_command_select_in,
	input  wire logic         read_strobe_in,
	input  wire logic         write_strobe_in,
	input  wire logic [7:0]   data_in,
	output logic      [7:0]   data_out,
	output logic              data_oe_n_out,
	// Display timing
	input  wire logic         frame_alternation_in,
	input  wire logic         display_line_clock_in,
	// Display side
	output logic      [131:0] segment_out,
	output logic      [6:0]   line_addr_out,
	output logic              com_reverse_out,
	output logic              indicator_common_pin_out,
	output logic              busy_out
);
	// Serial domain: shift state cleared whenever the chip is not selected
	typedef struct packed {
		logic [6:0] shift;
		logic [2:0] cnt;
	} lhr_ser_s;

	typedef struct packed {
		lhr_pkg::lhr_pins_s p1;
		lhr_pkg::lhr_pins_s p2;
		lhr_pkg::lhr_pins_s p3;
		logic [2:0] t;
		logic [7:0] holder;
		logic [7:0] col;
		logic       col_lock;
		logic [3:0] page;
		logic [5:0] start;
		logic       adc;
		logic       comdir;
		logic [3:0] busy_cnt;
		logic       commit;
		logic [6:0] line;
		logic [131:0] seg;
		logic [7:0] dout;
		logic       doe_n;
		logic       ind;
		logic       bsy;
	} lhr_state_s;

	lhr_ser_s              ser_reg;
	lhr_ser_s              ser_next;
	lhr_pkg::lhr_hand_s    hand_reg;
	lhr_pkg::lhr_hand_s    hand_next;
	lhr_state_s            st_reg;
	lhr_state_s            st_next;
	logic                  ser_rst_n;
	lhr_pkg::lhr_pins_s    pin_now;
	logic [7:0]            ram [0:lhr_pkg::RAM_WORDS-1];
	logic [10:0]           host_idx;
	logic                  host_ok;

	// Deselect or parallel mode holds the serial shifter in reset
	assign ser_rst_n = rst_n_in & ~chip_select_low_n_in & chip_select_high_in
		& ~interface_select_in;

	always_comb begin
		ser_next = ser_reg;
		hand_next = hand_reg;
		ser_next.shift = {ser_reg.shift[5:0], serial_data_in};
		ser_next.cnt = ser_reg.cnt + 3'h1;
		if (ser_reg.cnt == 3'h7) begin
			hand_next.word = {ser_reg.shift, serial_data_in};
			hand_next.dcs = data_command_select_in;
			hand_next.tog = ~hand_reg.tog;
		end
	end

	always_ff @(posedge serial_clk_in or negedge ser_rst_n) begin
		if (!ser_rst_n) begin
			ser_reg <= '0;
		end else begin
			ser_reg <= ser_next;
		end
	end

	// Handed byte survives a deselect so a finished byte is never lost
	always_ff @(posedge serial_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hand_reg <= '0;
		end else if (ser_rst_n) begin
			hand_reg <= hand_next;
		end
	end

	assign pin_now = '{
		ps:   interface_select_in,
		c86:  bus_style_select_in,
		cs_n: chip_select_low_n_in,
		cs:   chip_select_high_in,
		dcs:  data_command_select_in,
		rd:   read_strobe_in,
		wr:   write_strobe_in,
		fr:   frame_alternation_in,
		cl:   display_line_clock_in,
		d:    data_in
	};

	// Host address of the current page and column
	always_comb begin
		host_idx = 11'(st_reg.page * lhr_pkg::COLS) + 11'(st_reg.col);
		host_ok = (st_reg.page <= lhr_pkg::IND_PAGE) && (st_reg.col <= lhr_pkg::COL_LAST);
	end

	always_comb begin
		logic       sel;
		logic       par;
		logic       rd_start;
		logic       rd_act;
		logic       wr_end;
		logic       busy;
		logic       ser_new;
		logic       acc;
		logic       acc_dcs;
		logic [7:0] acc_d;
		logic       fr_chg;
		logic       cl_rise;
		logic [6:0] src_line;
		logic [131:0] row;
		logic [10:0] ridx;
		st_next = st_reg;
		sel = ~st_reg.p3.cs_n & st_reg.p3.cs;
		par = st_reg.p3.ps;
		busy = st_reg.busy_cnt != 4'h0;
		rd_start = 1'b0;
		rd_act = 1'b0;
		wr_end = 1'b0;
		ser_new = 1'b0;
		acc = 1'b0;
		acc_dcs = 1'b0;
		acc_d = 8'h00;
		fr_chg = 1'b0;
		cl_rise = 1'b0;
		src_line = 7'h00;
		row = '0;
		ridx = 11'h000;

		// Two flops before any logic; levels taken from the third, except D/C and R/W at read start from the second; edges from second against third
		st_next.p1 = pin_now;
		st_next.p2 = st_reg.p1;
		st_next.p3 = st_reg.p2;
		st_next.t = {st_reg.t[1:0], hand_reg.tog};

		if (st_reg.p3.c86) begin
			// Enable strobe high with read/write level
			rd_act = st_reg.p3.rd & st_reg.p3.wr;
			rd_start = ~st_reg.p3.rd & st_reg.p2.rd & st_reg.p2.wr;
			wr_end = st_reg.p3.rd & ~st_reg.p2.rd & ~st_reg.p3.wr;
		end else begin
			// Separate active-low read and write strobes
			rd_act = ~st_reg.p3.rd;
			rd_start = st_reg.p3.rd & ~st_reg.p2.rd;
			wr_end = ~st_reg.p3.wr & st_reg.p2.wr;
		end

		if (busy) begin
			st_next.busy_cnt = st_reg.busy_cnt - 4'h1;
		end

		// RAM commit one cycle after capture, before any later write
		if (st_reg.commit) begin
			st_next.commit = 1'b0;
			if (!st_reg.col_lock) begin
				st_next.col = st_reg.col + 8'h01;
			end
		end

		// Data pins driven only during an accepted read of a selected chip
		st_next.doe_n = 1'b1;
		if (sel && par && rd_act && (!st_reg.p3.dcs || !busy)) begin
			st_next.doe_n = 1'b0;
		end

		if (sel && par && rd_start) begin
			if (!st_reg.p2.dcs) begin
				st_next.dout = {busy, st_reg.adc, 6'h00};
			end else if (!busy) begin
				// Show what the last read fetched, fetch the next word
				st_next.dout = st_reg.holder;
				st_next.holder = host_ok ? ram[host_idx] : 8'h00;
				if (!st_reg.col_lock) begin
					st_next.col = st_reg.col + 8'h01;
				end
			end
		end

		ser_new = st_reg.t[2] ^ st_reg.t[1];
		if (par && sel && wr_end && !busy) begin
			acc = 1'b1;
			acc_dcs = st_reg.p3.dcs;
			acc_d = st_reg.p3.d;
		end else if (!par && ser_new && !busy) begin
			// Serial bytes arrive rarely, busy has long expired by then
			acc = 1'b1;
			acc_dcs = hand_reg.dcs;
			acc_d = hand_reg.word;
		end

		if (acc) begin
			st_next.busy_cnt = lhr_pkg::BUSY_LOAD;
			if (acc_dcs) begin
				st_next.holder = acc_d;
				st_next.commit = 1'b1;
			end else if ((acc_d & lhr_pkg::MSK_NIBBLE) == lhr_pkg::CMD_COL_LO) begin
				st_next.col = {st_reg.col[7:4], acc_d[3:0]};
				st_next.col_lock = {st_reg.col[7:4], acc_d[3:0]} > lhr_pkg::COL_LOCK;
			end else if ((acc_d & lhr_pkg::MSK_NIBBLE) == lhr_pkg::CMD_COL_HI) begin
				st_next.col = {acc_d[3:0], st_reg.col[3:0]};
				st_next.col_lock = {acc_d[3:0], st_reg.col[3:0]} > lhr_pkg::COL_LOCK;
			end else if ((acc_d & lhr_pkg::MSK_START) == lhr_pkg::CMD_START) begin
				st_next.start = acc_d[5:0];
			end else if ((acc_d & lhr_pkg::MSK_NIBBLE) == lhr_pkg::CMD_PAGE) begin
				st_next.page = acc_d[3:0];
			end else if ((acc_d & lhr_pkg::MSK_ADC) == lhr_pkg::CMD_ADC) begin
				st_next.adc = acc_d[0];
			end else if ((acc_d & lhr_pkg::MSK_NIBBLE) == lhr_pkg::CMD_OUTSEL) begin
				st_next.comdir = acc_d[lhr_pkg::OUTSEL_DIR];
			end
		end

		// Display scan reads its own row, never the host port
		fr_chg = st_reg.p3.fr ^ st_reg.p2.fr;
		cl_rise = ~st_reg.p3.cl & st_reg.p2.cl;
		src_line = st_reg.line;
		for (int i = 0; i < lhr_pkg::COLS; i++) begin
			if (src_line == lhr_pkg::IND_LINE) begin
				ridx = 11'(lhr_pkg::IND_PAGE * lhr_pkg::COLS + i);
				row[i] = ram[ridx][0];
			end else begin
				ridx = 11'(src_line[5:3] * lhr_pkg::COLS + i);
				row[i] = ram[ridx][src_line[2:0]];
			end
		end
		if (cl_rise) begin
			for (int i = 0; i < lhr_pkg::COLS; i++) begin
				st_next.seg[i] = st_reg.adc ? row[lhr_pkg::COLS-1-i] : row[i];
			end
			st_next.ind = src_line == lhr_pkg::IND_LINE;
			st_next.line = (st_reg.line == lhr_pkg::IND_LINE) ? 7'h00 : st_reg.line + 7'h01;
		end
		if (fr_chg) begin
			st_next.line = {1'b0, st_reg.start};
		end
		// Busy pin from its own flop so the output never glitches
		st_next.bsy = st_next.busy_cnt != 4'h0;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= '0;
			st_reg.page <= lhr_pkg::PAGE_RST;
			st_reg.col <= lhr_pkg::COL_RST;
			st_reg.start <= lhr_pkg::START_RST;
			st_reg.doe_n <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// Page 8 stores only bit 0 so the indicator row reads back clean
	always_ff @(posedge clk_in) begin
		if (st_reg.commit && host_ok) begin
			ram[host_idx] <= (st_reg.page == lhr_pkg::IND_PAGE) ?
				{7'h00, st_reg.holder[0]} : st_reg.holder;
		end
	end

	assign data_out = st_reg.dout;
	assign data_oe_n_out = st_reg.doe_n;
	assign segment_out = st_reg.seg;
	assign line_addr_out = st_reg.line;
	assign com_reverse_out = st_reg.comdir;
	assign indicator_common_pin_out = st_reg.ind;
	assign busy_out = st_reg.bsy;
endmodule
`default_nettype wire

/* File: tb/lhr_host_port_properties.sv */
// Port assertions of the LCD host RAM access block
`timescale 1ns/1ps
`default_nettype none
module lhr_host_port_properties (
	// Inputs
	input wire logic         clk_in,
	input wire logic         rst_n_in,
	input wire logic         interface_select_in,
	input wire logic         chip_select_low_n_in,
	input wire logic         frame_alternation_in,
	// Outputs
	input wire logic         data_oe_n_out,
	input wire logic [131:0] segment_out,
	input wire logic [6:0]   line_addr_out,
	input wire logic         com_reverse_out,
	input wire logic         busy_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// Six cycles spans the pin synchronisers and the output flop
	desel_float_a: assert property (chip_select_low_n_in [*6] |-> data_oe_n_out)
		else $error("drive while deselected");
	serial_quiet_a: assert property (!interface_select_in [*6] |-> data_oe_n_out)
		else $error("drive in serial mode");
	oe_cause_a: assert property ($fell(data_oe_n_out) |->
		$past(interface_select_in, 3) && !$past(chip_select_low_n_in, 3))
		else $error("drive without select");
	busy_len_a: assert property ($rose(busy_out) |-> busy_out [*5] ##1 !busy_out)
		else $error("busy length");
	line_range_a: assert property (line_addr_out <= lhr_pkg::IND_LINE)
		else $error("line range");
	line_step_a: assert property ($stable(frame_alternation_in) [*6] ##0
		$changed(line_addr_out) |-> line_addr_out == $past(line_addr_out) + 7'h1 ||
		line_addr_out == 7'h0)
		else $error("line step");
	com_busy_a: assert property ($changed(com_reverse_out) |-> ##[0:2] busy_out)
		else $error("scan change without command");
	seg_latch_a: assert property ($changed(segment_out) |-> ##[0:1] $changed(line_addr_out))
		else $error("segments without line clock");
	cover property ($rose(busy_out));
	cover property ($fell(data_oe_n_out));
	cover property ($rose(com_reverse_out));
endmodule
`default_nettype wire

/* File: tb/lhr_host_model.sv */
// Microprocessor model on the host pins of the LCD driver
`timescale 1ns/1ps
`default_nettype none
module lhr_host_model (
	// Clock and bus style
	input wire logic   clk_in,
	input wire logic   style_in,
	// Host pins
	output logic       dcs_out,
	output logic       rd_out,
	output logic       wr_out,
	output logic [7:0] d_out,
	output logic       sclk_out,
	output logic       sd_out
);
	logic act = 1'h0;
	logic rdl = 1'h1;
	// 6800: enable and R/W level; 8080: two low strobes
	assign rd_out = style_in ? act : !(act && rdl);
	assign wr_out = style_in ? rdl : !(act && !rdl);
	initial begin
		dcs_out = 1'h0;
		d_out = 8'h00;
		sclk_out = 1'h0;
		sd_out = 1'h0;
	end
	// Long strobes and spacing keep the cycle time, so busy is never polled
	task automatic acc(input logic rd, input logic dc, input logic [7:0] d);
		@(posedge clk_in);
		dcs_out <= dc;
		d_out <= d;
		rdl <= rd;
		repeat (2) @(posedge clk_in);
		act <= 1'h1;
		repeat (10) @(posedge clk_in);
		act <= 1'h0;
		repeat (8) @(posedge clk_in);
		d_out <= ~d;
		rdl <= 1'h1;
	endtask
	// Serial clock only inside a byte, offset from the system clock
	task automatic ser(input logic dc, input logic [7:0] b, input int n);
		dcs_out <= dc;
		#3.3;
		for (int i = 7; i > 7 - n; i--) begin
			sd_out = b[i];
			#40 sclk_out = 1'h1;
			#40 sclk_out = 1'h0;
		end
		#100 sd_out = ~sd_out;
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_lhr_host_port.sv */
// Self-checking bench of the LCD host RAM access block
`timescale 1ns/1ps
`default_nettype none
module tb_lhr_host_port;
	logic clk_in, rst_n_in, ps, c86, csn, cs, fr, lcl, dcs, rs, ws, sclk, sd, oe_n, comr, busy;
	logic [7:0]   hd, din, dout, a, b;
	logic [6:0]   line;
	logic [131:0] seg;
	logic [8:0]   exp_q[$];
	logic [8:0]   e;
	int           err_total, tests_run;
	// Bus level: the chip wins while it drives
	assign din = oe_n ? hd : dout;
	lhr_host_port dut_u (.clk_in, .rst_n_in, .serial_clk_in(sclk), .serial_data_in(sd),
		.interface_select_in(ps), .bus_style_select_in(c86), .chip_select_low_n_in(csn),
		.chip_select_high_in(cs), .data_command_select_in(dcs), .read_strobe_in(rs),
		.write_strobe_in(ws), .data_in(din), .data_out(dout), .data_oe_n_out(oe_n),
		.frame_alternation_in(fr), .display_line_clock_in(lcl), .segment_out(seg),
		.line_addr_out(line), .com_reverse_out(comr), .indicator_common_pin_out(),
		.busy_out(busy));
	lhr_host_model host_u (.clk_in, .style_in(c86), .dcs_out(dcs), .rd_out(rs),
		.wr_out(ws), .d_out(hd), .sclk_out(sclk), .sd_out(sd));
	task automatic chk(input logic [7:0] got, input logic [7:0] x);
		tests_run++;
		if (got !== x) begin
			err_total++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, x);
		end
	endtask
	task automatic wr(input logic dc, input logic [7:0] d);
		host_u.acc(1'h0, dc, d);
	endtask
	// Bit 8 set marks a dummy read whose data is not compared
	task automatic rd(input logic dc, input logic [8:0] x);
		exp_q.push_back(x);
		host_u.acc(1'h1, dc, 8'h00);
	endtask
	task automatic at(input logic [3:0] p, input logic [7:0] c);
		wr(1'h0, {4'hB, p});
		wr(1'h0, {4'h0, c[3:0]});
		wr(1'h0, {4'h1, c[7:4]});
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		clk_in = 1'h0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		repeat (30000) @(posedge clk_in);
		err_total++;
		complete_run();
	end
	always @(negedge oe_n) begin
		repeat (2) @(posedge clk_in);
		e = exp_q.pop_front();
		if (!e[8]) chk(dout, e[7:0]);
	end
	initial begin
		rst_n_in = 1'h0;
		{ps, c86, csn, cs, fr, lcl} = 6'h24;
		err_total = 0;
		tests_run = 0;
		void'($urandom(32'h2a0e));
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1'h1;
		for (int s = 0; s < 2; s++) begin
			c86 <= s[0];
			a = 8'($urandom);
			b = 8'($urandom);
			repeat (4) @(posedge clk_in);
			at(4'h2, 8'h05);
			wr(1'h1, a);
			wr(1'h1, b);
			at(4'h2, 8'h05);
			rd(1'h1, 9'h100);
			rd(1'h1, {1'h0, a});
			rd(1'h1, {1'h0, b});
			rd(1'h0, 9'h000);
			$display("bus style %0d done", s);
		end
		at(4'h8, 8'h82);
		wr(1'h1, 8'hFF);
		csn <= 1'h1;
		wr(1'h1, 8'h00);
		csn <= 1'h0;
		wr(1'h1, 8'h01);
		at(4'h8, 8'h82);
		rd(1'h1, 9'h100);
		rd(1'h1, 9'h001);
		rd(1'h1, 9'h001);
		rd(1'h1, 9'h000);
		$display("indicator done");
		ps <= 1'h0;
		repeat (4) @(posedge clk_in);
		host_u.ser(1'h1, 8'hFF, 3);
		@(posedge clk_in);
		csn <= 1'h1;
		repeat (4) @(posedge clk_in);
		csn <= 1'h0;
		a = 8'($urandom);
		host_u.ser(1'h0, 8'hB1, 8);
		host_u.ser(1'h0, 8'h07, 8);
		host_u.ser(1'h0, 8'h10, 8);
		host_u.ser(1'h1, a, 8);
		@(posedge clk_in);
		ps <= 1'h1;
		at(4'h1, 8'h07);
		rd(1'h1, 9'h100);
		rd(1'h1, {1'h0, a});
		$display("serial done");
		at(4'h0, 8'h00);
		wr(1'h1, 8'h04);
		wr(1'h0, 8'h42);
		wr(1'h0, 8'hC8);
		chk({7'h0, comr}, 8'h01);
		for (int r = 0; r < 2; r++) begin
			wr(1'h0, {7'h50, r[0]});
			fr <= ~fr;
			repeat (8) @(posedge clk_in);
			chk({1'h0, line}, 8'h02);
			lcl <= 1'h1;
			repeat (8) @(posedge clk_in);
			lcl <= 1'h0;
			chk({7'h0, seg[r ? 131 : 0]}, 8'h01);
			chk({1'h0, line}, 8'h03);
		end
		rd(1'h0, 9'h040);
		$display("display done");
		chk(8'(exp_q.size()), 8'h00);
		complete_run();
	end
endmodule
bind lhr_host_port lhr_host_port_properties chk_u (.clk_in, .rst_n_in, .interface_select_in,
	.chip_select_low_n_in, .frame_alternation_in, .data_oe_n_out, .segment_out,
	.line_addr_out, .com_reverse_out, .busy_out);
`default_nettype wire
